// [verilog/sbc_pkg.sv]
`default_nettype none
// ============================================================
// Serial link and watchdog-and-status register constants
package sbc_pkg;
  // Frame layout
  localparam logic [4:0] SBC_FRAME_BITS   = 5'h10;
  localparam logic [4:0] SBC_HDR_ADDR_BITS = 5'h03;
  localparam logic [4:0] SBC_CNT_MAX      = 5'h1f;
  localparam int         SBC_ADDR_HI      = 15;
  localparam int         SBC_ADDR_LO      = 13;
  localparam int         SBC_RO_BIT       = 12;
  // Register addresses
  localparam logic [2:0] SBC_ADDR_WDOG    = 3'h0;
  localparam logic [2:0] SBC_ADDR_MODE    = 3'h1;
  localparam logic [2:0] SBC_ADDR_INTCTL  = 3'h2;
  localparam logic [2:0] SBC_ADDR_INTSTAT = 3'h3;
  // Watchdog-and-status fields
  localparam int         SBC_MODE_BIT     = 11;
  localparam int         SBC_PERIOD_HI    = 10;
  localparam int         SBC_PERIOD_LO    = 8;
  localparam int         SBC_WOFF_BIT     = 7;
  localparam int         SBC_MAINLOW_BIT  = 6;
  localparam int         SBC_XCVRLOW_BIT  = 5;
  localparam int         SBC_WAKE_INPUT_ONE_BIT    = 4;
  localparam int         SBC_WAKE_INPUT_TWO_BIT    = 3;
  localparam logic [2:0] SBC_RSVD_VAL     = 3'h0;
  // Reset values
  localparam logic       SBC_MODE_RST     = 1'b0;
  localparam logic [2:0] SBC_PERIOD_RST   = 3'h4;
  // Synchronised pin indices
  localparam int         SBC_PIN_SCLK     = 0;
  localparam int         SBC_PIN_SEL_N    = 1;
  localparam int         SBC_PIN_SDI      = 2;
  localparam int         SBC_PIN_WOFF     = 3;
  localparam int         SBC_PIN_MAINLOW  = 4;
  localparam int         SBC_PIN_XCVRLOW  = 5;
  localparam int         SBC_PIN_WAKE_INPUT_ONE    = 6;
  localparam int         SBC_PIN_WAKE_INPUT_TWO    = 7;
  localparam int         SBC_NUM_PINS     = 8;
  // Idle level of each pin after reset: select high, rest low
  localparam logic [7:0] SBC_PIN_IDLE     = 8'h02;

  typedef enum logic {SBC_IDLE, SBC_FRAME} sbc_state_t;
endpackage
`default_nettype wire

// [verilog/sbc_pins_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Raw pins in, filtered levels and edges out
interface sbc_pins_if;
  import sbc_pkg::*;
  logic [SBC_NUM_PINS-1:0] raw;
  logic [SBC_NUM_PINS-1:0] level;
  logic [SBC_NUM_PINS-1:0] rise;
  logic [SBC_NUM_PINS-1:0] fall;
  modport syncer (input raw, output level, rise, fall);
  modport user   (output raw, input level, rise, fall);
endinterface
`default_nettype wire

// [verilog/sbc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Three-stage synchroniser with agreement filter per pin
module sbc_pin_sync (
  input  wire logic      clk,
  input  wire logic      reset,
  sbc_pins_if.syncer     pins
);
  import sbc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < SBC_NUM_PINS; i++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic lvl_d;

      // Only the second stage reads the first, to keep metastability contained
      always_ff @(posedge clk) begin
        if (reset) begin
          s1_q  <= SBC_PIN_IDLE[i];
          s2_q  <= SBC_PIN_IDLE[i];
          s3_q  <= SBC_PIN_IDLE[i];
          lvl_q <= SBC_PIN_IDLE[i];
        end else begin
          s1_q  <= pins.raw[i];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          lvl_q <= lvl_d;
        end
      end

      // A change counts once stages two and three agree
      assign lvl_d        = (s2_q == s3_q) ? s3_q : lvl_q;
      assign pins.level[i] = lvl_q;
      assign pins.rise[i]  = lvl_d & ~lvl_q;
      assign pins.fall[i]  = ~lvl_d & lvl_q;
    end
  endgenerate
endmodule
`default_nettype wire

// [verilog/sbc_spi_status.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Status shifts out while control shifts in
// RULE2 - Read-only access leaves register unchanged
// RULE3 - Select active low frames every transfer
// RULE4 - Host keeps serial clock low when idle
// RULE5 - Data output floats while select high
// RULE6 - Sample on falling, shift on rising
// RULE7 - First three bits address, MSB first
// RULE8 - Bit 12 set means read-only access
// RULE9 - Address 000 selects watchdog-and-status register
// RULE10 - Mode bit picks watchdog behaviour per mode
// RULE11 - Period field three bits, resets to 100
// RULE12 - Bit 7 shows pin disable; writing 1 resets
// RULE13 - Bit 6 flags main regulator undervoltage
// RULE14 - Bit 5 flags transceiver regulator undervoltage
// RULE15 - Bits 4, 3 show wake input levels
// RULE16 - Only complete 16-bit frames commit writes
// RULE17 - Reserved bits and address read constant
module sbc_spi_status (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       serial_select_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  input  wire logic       wdog_disable_pin,
  input  wire logic       main_reg_low,
  input  wire logic       xcvr_reg_low,
  input  wire logic       wake_input_one,
  input  wire logic       wake_input_two,
  output logic            wdog_mode_sel,
  output logic [2:0]      wdog_period_sel,
  output logic            wdog_off,
  output logic            sw_reset_req
);
  import sbc_pkg::*;

  // ============================================================
  // Pin synchronisation
  sbc_pins_if pins ();

  assign pins.raw[SBC_PIN_SCLK]    = sclk;
  assign pins.raw[SBC_PIN_SEL_N]   = serial_select_n;
  assign pins.raw[SBC_PIN_SDI]     = sdi;
  assign pins.raw[SBC_PIN_WOFF]    = wdog_disable_pin;
  assign pins.raw[SBC_PIN_MAINLOW] = main_reg_low;
  assign pins.raw[SBC_PIN_XCVRLOW] = xcvr_reg_low;
  assign pins.raw[SBC_PIN_WAKE_INPUT_ONE]   = wake_input_one;
  assign pins.raw[SBC_PIN_WAKE_INPUT_TWO]   = wake_input_two;

  sbc_pin_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .pins  (pins)
  );

  logic selected;
  logic sel_start;
  logic sel_end;
  logic sclk_fall;
  logic sclk_rise;

  // Serial activity only counts inside a selected frame
  assign selected  = ~pins.level[SBC_PIN_SEL_N];                        // RULE3
  assign sel_start = pins.fall[SBC_PIN_SEL_N];                          // RULE3
  assign sel_end   = pins.rise[SBC_PIN_SEL_N];                          // RULE3
  // Host idles the clock low, so the first edge in a frame is a rise
  assign sclk_fall = pins.fall[SBC_PIN_SCLK] & selected;                // RULE6 RULE4
  assign sclk_rise = pins.rise[SBC_PIN_SCLK] & selected;                // RULE6

  // ============================================================
  // Frame state
  sbc_state_t state_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= SBC_IDLE;
    end else begin
      case (state_q)
        SBC_IDLE: begin
          if (sel_start) begin
            state_q <= SBC_FRAME;
          end
        end
        SBC_FRAME: begin
          if (sel_end) begin
            state_q <= SBC_IDLE;
          end
        end
        default: begin
          state_q <= SBC_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Receive path: bit counter and input shifter
  logic [4:0]  cnt_q;
  logic [15:0] rx_q;
  logic [15:0] rx_d;

  assign rx_d = {rx_q[14:0], pins.level[SBC_PIN_SDI]};

  // Counter saturates so an overlong frame can never alias to 16
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 5'h00;
    end else if (sel_start) begin
      cnt_q <= 5'h00;
    end else if (sclk_fall && state_q == SBC_FRAME && cnt_q != SBC_CNT_MAX) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Bits arrive most significant first
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_q <= 16'h0000;
    end else if (sel_start) begin
      rx_q <= 16'h0000;
    end else if (sclk_fall && state_q == SBC_FRAME) begin
      rx_q <= rx_d;                                                     // RULE6 RULE7
    end
  end

  // ============================================================
  // Watchdog-and-status register storage
  logic       mode_q;
  logic [2:0] period_q;
  logic       swr_q;
  logic       commit;
  logic [2:0] rx_addr;
  logic       rx_ro;

  assign rx_addr = rx_q[SBC_ADDR_HI:SBC_ADDR_LO];                       // RULE7
  assign rx_ro   = rx_q[SBC_RO_BIT];                                    // RULE8
  // Commit at select release, exact length, own address, write access
  assign commit  = sel_end && state_q == SBC_FRAME && cnt_q == SBC_FRAME_BITS
                   && rx_addr == SBC_ADDR_WDOG && !rx_ro;               // RULE16 RULE9 RULE8 RULE2

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q   <= SBC_MODE_RST;
      period_q <= SBC_PERIOD_RST;                                       // RULE11
    end else if (commit) begin
      mode_q   <= rx_q[SBC_MODE_BIT];                                   // RULE10
      period_q <= rx_q[SBC_PERIOD_HI:SBC_PERIOD_LO];                    // RULE11
    end
  end

  // A written 1 in the disable bit requests a one-cycle software reset
  always_ff @(posedge clk) begin
    if (reset) begin
      swr_q <= 1'b0;
    end else begin
      swr_q <= commit & rx_q[SBC_WOFF_BIT];                             // RULE12
    end
  end

  assign wdog_mode_sel   = mode_q;                                      // RULE10
  assign wdog_period_sel = period_q;
  assign sw_reset_req    = swr_q;

  // Registered pin level, independent of the mode bit; the watchdog engine reads this
  always_ff @(posedge clk) begin
    if (reset) begin
      wdog_off <= 1'b0;
    end else begin
      wdog_off <= pins.level[SBC_PIN_WOFF];                             // RULE12
    end
  end

  // ============================================================
  // Reply word for the addressed register
  logic [12:0] reply;

  // Registers outside this block answer with zero data
  always_comb begin
    reply = 13'h0000;
    if (rx_d[2:0] == SBC_ADDR_WDOG) begin                               // RULE9
      reply[SBC_MODE_BIT]                  = mode_q;
      reply[SBC_PERIOD_HI:SBC_PERIOD_LO]   = period_q;
      reply[SBC_WOFF_BIT]                  = pins.level[SBC_PIN_WOFF];  // RULE12
      reply[SBC_MAINLOW_BIT]               = pins.level[SBC_PIN_MAINLOW]; // RULE13
      reply[SBC_XCVRLOW_BIT]               = pins.level[SBC_PIN_XCVRLOW]; // RULE14
      reply[SBC_WAKE_INPUT_ONE_BIT]                 = pins.level[SBC_PIN_WAKE_INPUT_ONE];  // RULE15
      reply[SBC_WAKE_INPUT_TWO_BIT]                 = pins.level[SBC_PIN_WAKE_INPUT_TWO];  // RULE15
      reply[2:0]                           = SBC_RSVD_VAL;              // RULE17
    end
  end

  // ============================================================
  // Transmit path
  // Header bits go out as the watchdog register's fixed address, since
  // the address is not known until the third bit is in. The reply is
  // loaded on that third sample, ahead of the rise that shows bit 12.
  logic [15:0] tx_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= 16'h0000;
    end else if (sel_start) begin
      tx_q <= {SBC_ADDR_WDOG, 13'h0000};                                // RULE17
    end else if (sclk_fall && state_q == SBC_FRAME
                 && cnt_q == SBC_HDR_ADDR_BITS - 5'h01) begin
      // Keep the bit on the line; reply bit 12 is next out, bit 0 is last
      tx_q <= {tx_q[15], reply, 2'b00};                                 // RULE1
    end else if (sclk_rise && state_q == SBC_FRAME) begin
      tx_q <= {tx_q[14:0], 1'b0};                                       // RULE6 RULE1
    end
  end

  // Drive only inside a selected frame
  assign sdo    = tx_q[15];
  assign sdo_oe = selected && state_q == SBC_FRAME;                     // RULE5
endmodule
`default_nettype wire

// [testbench/sbc_spi_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks of the serial status block
module sbc_spi_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       sclk,
  input wire logic       serial_select_n,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic       wdog_disable_pin,
  input wire logic       wdog_mode_sel,
  input wire logic [2:0] wdog_period_sel,
  input wire logic       wdog_off,
  input wire logic       sw_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Output enable tracks the filtered select
  property p_oe_idle; serial_select_n [*6] |-> !sdo_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
  property p_oe_sel; !serial_select_n [*6] |-> sdo_oe; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("sdo not driven while selected");
  // Defaults stand at the first edge after release
  property p_rst; $fell(reset) |-> wdog_period_sel == 3'h4 && !wdog_mode_sel && !sw_reset_req; endproperty
  a_rst: assert property (p_rst) else $error("wrong value after reset");
  // Software reset request is a single pulse, only after deselect
  property p_swr_pulse; sw_reset_req |=> !sw_reset_req; endproperty
  a_swr_pulse: assert property (p_swr_pulse) else $error("reset request too long");
  property p_swr_sel; sw_reset_req |-> serial_select_n && $past(serial_select_n, 3); endproperty
  a_swr_sel: assert property (p_swr_sel) else $error("reset request inside frame");
  // Stored fields move only once a frame has closed
  property p_cfg; ($changed(wdog_period_sel) || $changed(wdog_mode_sel)) |->
    serial_select_n && $past(serial_select_n, 3); endproperty
  a_cfg: assert property (p_cfg) else $error("register changed inside frame");
  // Filtered disable pin settles within the synchroniser lag
  property p_woff; (!reset && $stable(wdog_disable_pin)) [*6] |-> wdog_off == wdog_disable_pin; endproperty
  a_woff: assert property (p_woff) else $error("disable level not followed");
  // Output bit moves only after a serial clock rise
  property p_sdo; $changed(sdo) && sdo_oe && $past(sdo_oe) |-> $past(sclk, 4); endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved off the rising edge");
endmodule
bind sbc_spi_status sbc_spi_chk chk (.clk(clk), .reset(reset), .sclk(sclk),
  .serial_select_n(serial_select_n), .sdo(sdo), .sdo_oe(sdo_oe), .wdog_disable_pin(wdog_disable_pin),
  .wdog_mode_sel(wdog_mode_sel), .wdog_period_sel(wdog_period_sel), .wdog_off(wdog_off),
  .sw_reset_req(sw_reset_req));
`default_nettype wire

// [testbench/sbc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host acting as serial master, 320 ns serial clock
module sbc_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      serial_select_n,
  output logic      sdi,
  input  wire logic sdo_line
);
  // Idle: deselected, clock low
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    sdi = 1'b0;
  end
  // One frame of n bits, MSB first; reply read late in the low phase to absorb device lag
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk) serial_select_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      sdi <= tx[15 - (i % 16)];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
      rx = {rx[14:0], sdo_line};
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    serial_select_n <= 1'b1;
    sdi <= ~sdi;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
// ============================================================
// Bench top
module tb_top;
  import sbc_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [4:0] st = 5'h00;
  logic       sclk, serial_select_n, sdi, sdo, sdo_oe, mode, woff, swr;
  logic [2:0] period;
  logic [15:0] rx;
  int         fail_count = 0;
  int         total_checks = 0;
  int         swr_count = 0;
  wire        sdo_line = sdo_oe ? sdo : 1'bz;
  always #20 clk = ~clk;
  // Count reset request pulses
  always @(posedge clk) if (swr === 1'b1) swr_count++;
  sbc_host_model host (.clk(clk), .sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi), .sdo_line(sdo_line));
  sbc_spi_status DUT (.clk(clk), .reset(reset), .sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .wdog_disable_pin(st[4]), .main_reg_low(st[3]), .xcvr_reg_low(st[2]),
    .wake_input_one(st[1]), .wake_input_two(st[0]), .wdog_mode_sel(mode), .wdog_period_sel(period),
    .wdog_off(woff), .sw_reset_req(swr));
  // Expected reply from the watchdog-and-status register
  function automatic logic [15:0] exp_rx(logic m, logic [2:0] p);
    return {4'h0, m, p, st, 3'h0};
  endfunction
  task automatic do_reset;
    @(posedge clk) reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    `CHK({mode, period}, {SBC_MODE_RST, SBC_PERIOD_RST})
    `CHK(sdo_line, 1'bz)
    // Every period code and both modes; reserved bits and status bits 6 to 3 written as ones, disable bit 7 as zero
    for (int i = 0; i < 8; i++) begin
      st <= {1'b0, i[2:0], ~i[0]};
      host.xfer({4'h0, i[0], i[2:0], 8'h7f}, 16, rx);
      `CHK({mode, period}, {i[0], i[2:0]})
      host.xfer(16'h1fff, 16, rx);
      `CHK(rx, exp_rx(i[0], i[2:0]))
    end
    `CHK({mode, period}, 4'hf)
    // Disable pin high, then a software reset write
    st <= 5'h10;
    host.xfer(16'h0080, 16, rx);
    `CHK(swr_count, 1)
    `CHK(woff, 1'b1)
    host.xfer(16'h1000, 16, rx);
    `CHK(rx, exp_rx(1'b0, 3'h0))
    // Frames one bit short and one bit long
    for (int n = 15; n <= 17; n += 2) host.xfer(16'h0e80, n, rx);
    `CHK({mode, period, swr_count[1:0]}, 6'h01)
    // Other address: zero data back, nothing stored
    host.xfer(16'h2e00, 16, rx);
    `CHK(rx, 16'h0000)
    `CHK({mode, period}, 4'h0)
    do_reset();
    `CHK({mode, period}, {SBC_MODE_RST, SBC_PERIOD_RST})
    test_done();
  end
endmodule
`default_nettype wire
